// file: core/blrs_pkg.sv
// package for the break, low-power and reset-status block
package blrs_pkg;
   // register byte offsets
   localparam logic [15:0] BLRS_OFF_BREAK_STATUS = 16'hFE00;
   localparam logic [15:0] BLRS_OFF_RESET_CAUSE = 16'hFE01;
   localparam logic [15:0] BLRS_OFF_BREAK_FLAG_CONTROL = 16'hFE03;
   localparam logic [15:0] BLRS_OFF_OPTION = 16'hFE04;
   // field positions
   localparam int BLRS_BIT_BREAK_WAIT = 1;
   localparam int BLRS_BIT_BREAK_CLEAR_ENABLE = 7;
   localparam int BLRS_BIT_POR = 7;
   localparam int BLRS_BIT_PIN = 6;
   localparam int BLRS_BIT_WDOG = 5;
   localparam int BLRS_BIT_BAD_OPCODE = 4;
   localparam int BLRS_BIT_BAD_ADDRESS = 3;
   localparam int BLRS_BIT_LOW_VOLTAGE = 1;
   localparam int BLRS_BIT_OPT_STOP_ENABLE = 0;
   localparam int BLRS_BIT_OPT_SHORT_REC = 1;
   localparam int BLRS_BIT_OPT_WDOG_DIS = 2;
   // reset values
   localparam logic [7:0] BLRS_RST_OPTION = 8'h01;
   localparam logic [7:0] BLRS_RST_CAUSE_POR = 8'h80;
   // recovery timing in crystal clock cycles
   localparam int BLRS_REC_LONG = 4096;
   localparam int BLRS_REC_SHORT = 32;
   localparam int BLRS_CNT_W = 13;
   localparam logic [1:0] BLRS_RESP_OKAY = 2'b00;
   localparam logic [1:0] BLRS_RESP_SLVERR = 2'b10;

   typedef enum {BLRS_RUN, BLRS_WAIT, BLRS_STOP, BLRS_RECOVER,
                 BLRS_BREAK} blrs_state_type;

   // reset sources arriving together
   typedef struct packed {
      logic por;
      logic pin;
      logic wdog;
      logic bad_opcode;
      logic bad_address;
      logic low_voltage;
   } blrs_reset_src_type;

   // cpu events
   typedef struct packed {
      logic wait_exec;
      logic stop_exec;
      logic interrupt_req;
      logic break_req;
      logic break_exit;
   } blrs_cpu_evt_type;
endpackage

// file: core/blrs_top.sv
// break, low-power sequencing and reset-status block
// ----------------------------------------------------------------------
// Functional notes
// - break request forces cpu to fetch the software interrupt vector.
// - in break with clear enable low, block all peripheral flag clears.
// - with clear enable high, flags clear during break and stay cleared.
// - two-step flag clears stay blocked in break unless clear enable is high; second step works after.
// - wait or stop gates cpu clock and clears the interrupt mask.
// - wait stops cpu clocks, peripheral clocks keep running.
// - wait exits on enabled interrupt, stacking one cycle later.
// - wait also ends on reset or break; break sets break-wait flag.
// - watchdog-disable option low keeps watchdog running in wait.
// - stop resets system counter and gates base and crystal clocks.
// - stop ends on interrupt or reset; stacking after recovery delay.
// - recovery is 4096 cycles, or 32 with short-recovery option set.
// - break inactive in stop; break registers untouched by stop.
// - system counter held reset in stop, then times recovery.
// - three registers mapped at fe00, fe01 and fe03.
// - break-wait flag set on break exit from wait, cleared by 0 or reset.
// - reset-cause register holds six last-reset-source flags.
// - reading reset-cause clears all its flags.
// - power-on sets power-on flag and clears all other cause flags.
// - break-clear enable is read-write; 1 clearable, 0 protected.
// - stop with stop-enable option low causes a bad-opcode reset.
// - system counter is 13 bits, stepped on crystal falling edge.
// ----------------------------------------------------------------------
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module blrs_top
   import blrs_pkg::*;
#(
   parameter int REC_LONG_CYCLES = BLRS_REC_LONG
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // crystal clock falling-edge enable
   input wire logic xtal_fall_en,
   // axi4-lite write address
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu and reset sources
   input wire blrs_cpu_evt_type cpu_evt,
   input wire blrs_reset_src_type reset_src,
   input wire logic periph_flag_clear_req,
   input wire logic periph_two_step_second,
   // cpu and clock control
   output logic force_swi_vector,
   output logic clear_int_mask,
   output logic start_stacking,
   output logic cpu_clock_en,
   output logic periph_clock_en,
   output logic base_clock_out_en,
   output logic crystal_clock_en,
   output logic watchdog_run,
   output logic in_break,
   output logic periph_flag_clear_allow,
   output logic bad_opcode_reset,
   output logic [BLRS_CNT_W-1:0] sys_counter
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] word_addr(input logic [15:0] a);
      word_addr = {a[15:2], 2'b00};
   endfunction

   blrs_state_type state;
   blrs_state_type next_state;
   logic break_wait_flag;
   logic break_clear_enable;
   logic [7:0] reset_cause;
   logic [7:0] option_register;
   logic [7:0] next_cause;
   logic two_step_armed;

   // ----------------------------------------------------------------
   // register bus: both write channels taken together when idle
   // ----------------------------------------------------------------
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   wire [15:0] waddr = word_addr(s_axi_awaddr);
   wire [15:0] raddr = word_addr(s_axi_araddr);
   wire wr_lane0 = s_axi_wstrb[0];
   wire wr_lane1 = s_axi_wstrb[1];
   wire wr_lane3 = s_axi_wstrb[3];
   // status, cause and control registers sit on byte lanes of the word at fe00; option sits at fe04
   wire wr_sel_word = wr_go && (waddr == BLRS_OFF_BREAK_STATUS);
   wire wr_sel_opt = wr_go && (waddr == BLRS_OFF_OPTION);
   wire wr_bad = wr_go && !wr_sel_word && !wr_sel_opt;
   wire rd_sel_word = rd_go && (raddr == BLRS_OFF_BREAK_STATUS);
   wire rd_sel_opt = rd_go && (raddr == BLRS_OFF_OPTION);
   wire rd_bad = rd_go && !rd_sel_word && !rd_sel_opt;
   wire [7:0] status_rd = 8'(break_wait_flag) << BLRS_BIT_BREAK_WAIT;
   wire [7:0] ctrl_rd = 8'(break_clear_enable)
                        << BLRS_BIT_BREAK_CLEAR_ENABLE;
   wire [31:0] word_rd = {ctrl_rd, 8'h00, reset_cause, status_rd};
   wire [31:0] next_rdata = rd_sel_opt ? {24'h000000, option_register} :
                            (rd_sel_word ? word_rd : 32'h00000000);
   wire cause_read = rd_sel_word;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= BLRS_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= BLRS_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? BLRS_RESP_SLVERR : BLRS_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_bad ? BLRS_RESP_SLVERR : BLRS_RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // low-power and break sequencer
   // ----------------------------------------------------------------
   wire stop_allowed = option_register[BLRS_BIT_OPT_STOP_ENABLE];
   wire short_rec = option_register[BLRS_BIT_OPT_SHORT_REC];
   wire [BLRS_CNT_W:0] rec_target = short_rec ?
        (BLRS_CNT_W+1)'(BLRS_REC_SHORT) :
        (BLRS_CNT_W+1)'(REC_LONG_CYCLES);
   logic [BLRS_CNT_W:0] rec_count;
   wire rec_done = (rec_count >= rec_target);
   assign bad_opcode_reset = (state == BLRS_RUN) && cpu_evt.stop_exec
                             && !stop_allowed;

   always_comb begin
      next_state = state;
      unique case (state)
         BLRS_RUN: begin
            if (cpu_evt.break_req) begin
               next_state = BLRS_BREAK;
            end else if (cpu_evt.wait_exec) begin
               next_state = BLRS_WAIT;
            end else if (cpu_evt.stop_exec && stop_allowed) begin
               next_state = BLRS_STOP;
            end
         end
         BLRS_WAIT: begin
            if (cpu_evt.break_req) begin
               next_state = BLRS_BREAK;
            end else if (cpu_evt.interrupt_req) begin
               next_state = BLRS_RUN;
            end
         end
         BLRS_STOP: begin
            if (cpu_evt.interrupt_req) begin
               next_state = BLRS_RECOVER;
            end
         end
         BLRS_RECOVER: begin
            if (rec_done) begin
               next_state = BLRS_RUN;
            end
         end
         BLRS_BREAK: begin
            if (cpu_evt.break_exit) begin
               next_state = BLRS_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= BLRS_RUN;
      end else begin
         state <= next_state;
      end
   end

   // outputs registered from the next state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_swi_vector <= 1'b0;
         clear_int_mask <= 1'b0;
         start_stacking <= 1'b0;
      end else begin
         force_swi_vector <= (state != BLRS_BREAK)
                             && (next_state == BLRS_BREAK);
         clear_int_mask <= (state == BLRS_RUN) && ((next_state == BLRS_WAIT)
                           || (next_state == BLRS_STOP));
         start_stacking <= ((state == BLRS_WAIT) && (next_state == BLRS_RUN))
                           || ((state == BLRS_RECOVER) && rec_done);
      end
   end

   // break is never entered from stop, so break state stays untouched
   assign in_break = (state == BLRS_BREAK);
   assign cpu_clock_en = (state == BLRS_RUN) || (state == BLRS_BREAK);
   assign periph_clock_en = (state != BLRS_STOP)
                            && (state != BLRS_RECOVER);
   assign base_clock_out_en = (state != BLRS_STOP);
   assign crystal_clock_en = (state != BLRS_STOP);
   assign watchdog_run = !option_register[BLRS_BIT_OPT_WDOG_DIS]
                         && (state != BLRS_STOP);

   // ----------------------------------------------------------------
   // system counter on the crystal falling-edge enable
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_counter <= '0;
         rec_count <= '0;
      end else if (state == BLRS_STOP) begin
         sys_counter <= '0;
         rec_count <= '0;
      end else if (xtal_fall_en) begin
         sys_counter <= sys_counter + 1'b1;
         if (state == BLRS_RECOVER && !rec_done) begin
            rec_count <= rec_count + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // break flag protection
   // ----------------------------------------------------------------
   // a second step counts once any cycle outside break has passed since reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         two_step_armed <= 1'b0;
      end else if (in_break) begin
         two_step_armed <= two_step_armed;
      end else begin
         two_step_armed <= 1'b1;
      end
   end
   assign periph_flag_clear_allow = (!in_break || break_clear_enable)
        && (periph_flag_clear_req || (periph_two_step_second
            && (!in_break || break_clear_enable) && two_step_armed));

   // ----------------------------------------------------------------
   // status, control and option registers
   // ----------------------------------------------------------------
   wire bw_set = (state == BLRS_WAIT) && cpu_evt.break_req;
   wire bw_clr = wr_sel_word && wr_lane0
                 && !s_axi_wdata[BLRS_BIT_BREAK_WAIT];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         break_wait_flag <= 1'b0;
         break_clear_enable <= 1'b0;
         option_register <= BLRS_RST_OPTION;
      end else begin
         if (bw_set) begin
            break_wait_flag <= 1'b1;
         end else if (bw_clr) begin
            break_wait_flag <= 1'b0;
         end
         if (wr_sel_word && wr_lane3) begin
            break_clear_enable <=
               s_axi_wdata[24+BLRS_BIT_BREAK_CLEAR_ENABLE];
         end
         if (wr_sel_opt && wr_lane0) begin
            option_register <= s_axi_wdata[7:0] & 8'h07;
         end
      end
   end

   // reset cause: new sources win over the read-clear
   always_comb begin
      next_cause = cause_read ? 8'h00 : reset_cause;
      if (reset_src.pin) next_cause[BLRS_BIT_PIN] = 1'b1;
      if (reset_src.wdog) next_cause[BLRS_BIT_WDOG] = 1'b1;
      if (reset_src.bad_opcode || bad_opcode_reset) begin
         next_cause[BLRS_BIT_BAD_OPCODE] = 1'b1;
      end
      if (reset_src.bad_address) next_cause[BLRS_BIT_BAD_ADDRESS] = 1'b1;
      if (reset_src.low_voltage) next_cause[BLRS_BIT_LOW_VOLTAGE] = 1'b1;
      if (reset_src.por) next_cause = BLRS_RST_CAUSE_POR;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_cause <= BLRS_RST_CAUSE_POR;
      end else begin
         reset_cause <= next_cause;
      end
   end

   wire unused_ok = wr_lane1;
endmodule

// file: verif/blrs_sva.sv
// assertion checker for the break, low-power and reset-status block
`timescale 1ns/1ps
module blrs_sva
   import blrs_pkg::*;
#(
   parameter int REC_LONG_CYCLES = BLRS_REC_LONG
) (
   // clock, reset and crystal step
   input wire logic aclk, aresetn, xtal_fall_en,
   // axi4-lite
   input wire logic [15:0] s_axi_awaddr, s_axi_araddr,
   input wire logic [31:0] s_axi_wdata, s_axi_rdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu and clock side
   input wire blrs_cpu_evt_type cpu_evt,
   input wire blrs_reset_src_type reset_src,
   input wire logic periph_flag_clear_req, periph_two_step_second,
   input wire logic force_swi_vector, clear_int_mask, start_stacking,
   input wire logic cpu_clock_en, periph_clock_en, base_clock_out_en,
   input wire logic crystal_clock_en, watchdog_run, in_break,
   input wire logic periph_flag_clear_allow, bad_opcode_reset,
   input wire logic [BLRS_CNT_W-1:0] sys_counter
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------
   // low-power steps
   // ----------------
   sequence in_wait_s;
      !cpu_clock_en && periph_clock_en;
   endsequence
   sequence wait_go_s;
      cpu_evt.wait_exec && cpu_clock_en && !in_break && !cpu_evt.break_req;
   endsequence
   sequence wake_s;
      in_wait_s ##0 (cpu_evt.interrupt_req && !cpu_evt.break_req);
   endsequence
   swi_on_break_a: assert property ($rose(in_break)
      |-> ##[0:1] force_swi_vector)
      else $error("break entered without vector fetch");
   wait_mask_a: assert property (wait_go_s
      |-> ##[1:2] clear_int_mask)
      else $error("interrupt mask not cleared on wait");
   wait_clocks_a: assert property (wait_go_s
      |-> ##[1:2] in_wait_s)
      else $error("wait clocks wrong");
   wait_wake_a: assert property (wake_s
      |-> ##[1:2] start_stacking)
      else $error("no stacking after wait wake");
   wait_break_a: assert property (in_wait_s ##0 cpu_evt.break_req
      |-> ##[1:2] in_break)
      else $error("break did not end wait");
   stop_quiet_a: assert property (!crystal_clock_en
      |-> !base_clock_out_en && !in_break && !cpu_clock_en
          && !periph_clock_en)
      else $error("stop left clock or break active");
   stop_count_a: assert property ($fell(crystal_clock_en)
      |-> ##[0:1] sys_counter == 0)
      else $error("counter not cleared in stop");
   counter_step_a: assert property (xtal_fall_en
      && base_clock_out_en |=> sys_counter == $past(sys_counter) + 1'b1)
      else $error("system counter did not step");
   clear_free_a: assert property (!in_break && periph_flag_clear_req
      |-> periph_flag_clear_allow)
      else $error("flag clear blocked outside break");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read not answered");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered");
endmodule

bind blrs_top blrs_sva #(.REC_LONG_CYCLES(REC_LONG_CYCLES)) blrs_sva_i (.*);

// file: verif/blrs_cpu_model.sv
// behavioural cpu core and crystal source facing the block
`timescale 1ns/1ps
module blrs_cpu_model
   import blrs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // event request from the bench
   input wire blrs_cpu_evt_type evt_req,
   // towards the block
   output blrs_cpu_evt_type cpu_evt,
   output logic xtal_fall_en
);
   // ----------------
   // crystal and cpu events
   // ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xtal_fall_en <= 1'b0;
         cpu_evt <= '0;
      end else begin
         xtal_fall_en <= !xtal_fall_en;
         cpu_evt <= evt_req;
      end
   end
endmodule

// file: verif/tb.sv
// self-checking bench for the break, low-power and reset-status block
`timescale 1ns/1ps
module tb
   import blrs_pkg::*;
   ;
   localparam int REC_SIM = 64;
   localparam blrs_cpu_evt_type E_WAIT = 5'h10, E_STOP = 5'h08;
   localparam blrs_cpu_evt_type E_INT = 5'h04, E_BRK = 5'h02, E_EXIT = 5'h01;
   logic aclk = 1'b0, aresetn = 1'b0, xtal_fall_en;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, force_swi_vector, clear_int_mask, start_stacking;
   logic cpu_clock_en, periph_clock_en, base_clock_out_en, crystal_clock_en;
   logic watchdog_run, in_break, periph_flag_clear_allow, bad_opcode_reset;
   logic periph_flag_clear_req = 1'b0, periph_two_step_second = 1'b0;
   logic swi_seen = 1'b0, bad_seen = 1'b0;
   logic [BLRS_CNT_W-1:0] sys_counter;
   blrs_cpu_evt_type cpu_evt, evt_req = '0;
   blrs_reset_src_type reset_src = '0;
   int n_mismatch = 0, n_compared = 0, n_xt;

   blrs_top #(.REC_LONG_CYCLES(REC_SIM)) blrs_top_i (.*);
   blrs_cpu_model blrs_cpu_model_i (.*);

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (force_swi_vector === 1'b1) swi_seen <= 1'b1;
      if (bad_opcode_reset === 1'b1) bad_seen <= 1'b1;
   end
   // ----------------
   // checks and bus tasks
   // ----------------
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic lost();
      n_mismatch++;
      $display("mismatch at %0t: wait timed out", $time);
      wrap_up();
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: word %h, expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: flag %b, expected %b", $time, g, e);
      end
   endtask
   task automatic axw(input logic [15:0] a, input logic [31:0] d);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (k == 50) lost();
      chk32({30'h0, s_axi_bresp}, {30'h0, BLRS_RESP_OKAY});
   endtask
   task automatic axr(input logic [15:0] a, input logic [31:0] e,
                      input logic [1:0] r);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (k == 50) lost();
      chk32(s_axi_rdata, e);
      chk32({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   task automatic evt(input blrs_cpu_evt_type e);
      evt_req <= e;
      @(posedge aclk);
      evt_req <= '0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic wait_stack(input blrs_cpu_evt_type e);
      int k;
      n_xt = 0;
      evt_req <= e;
      for (k = 0; k < 400; k++) begin
         @(posedge aclk);
         if (k == 0) evt_req <= '0;
         if (start_stacking === 1'b1) break;
         if (xtal_fall_en === 1'b1) n_xt++;
      end
      if (k == 400) lost();
   endtask
   // ----------------
   // main sequence
   // ----------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(BLRS_OFF_BREAK_STATUS, 32'h0000_8000, BLRS_RESP_OKAY);
      axr(BLRS_OFF_BREAK_STATUS, 32'h0, BLRS_RESP_OKAY);
      axr(BLRS_OFF_OPTION, {24'h0, BLRS_RST_OPTION}, BLRS_RESP_OKAY);
      axr(16'h0010, 32'h0, BLRS_RESP_SLVERR);
      axw(BLRS_OFF_BREAK_STATUS, 32'hFFFF_FFFF);
      axr(BLRS_OFF_BREAK_STATUS, 32'h8000_0000, BLRS_RESP_OKAY);
      axw(BLRS_OFF_BREAK_STATUS, 32'h0);
      axr(BLRS_OFF_BREAK_STATUS, 32'h0, BLRS_RESP_OKAY);
      $display("test registers done");
      evt(E_WAIT);
      chk1(cpu_clock_en, 1'b0);
      chk1(periph_clock_en, 1'b1);
      chk1(watchdog_run, 1'b1);
      wait_stack(E_INT);
      chk1(cpu_clock_en, 1'b1);
      $display("test wait done");
      periph_flag_clear_req <= 1'b1;
      periph_two_step_second <= 1'b1;
      evt(E_WAIT);
      evt(E_BRK);
      chk1(in_break, 1'b1);
      chk1(swi_seen, 1'b1);
      chk1(periph_flag_clear_allow, 1'b0);
      axr(BLRS_OFF_BREAK_STATUS, 32'h2, BLRS_RESP_OKAY);
      axw(BLRS_OFF_BREAK_STATUS, 32'h8000_0002);
      chk1(periph_flag_clear_allow, 1'b1);
      evt(E_EXIT);
      chk1(in_break, 1'b0);
      chk1(periph_flag_clear_allow, 1'b1);
      axw(BLRS_OFF_BREAK_STATUS, 32'h0);
      axr(BLRS_OFF_BREAK_STATUS, 32'h0, BLRS_RESP_OKAY);
      periph_flag_clear_req <= 1'b0;
      periph_two_step_second <= 1'b0;
      $display("test break done");
      for (int s = 0; s < 2; s++) begin
         axw(BLRS_OFF_OPTION, {30'h0, s[0], 1'b1});
         evt(E_STOP);
         evt(E_BRK);
         chk1(crystal_clock_en, 1'b0);
         chk1(base_clock_out_en, 1'b0);
         chk1(in_break, 1'b0);
         chk32({19'h0, sys_counter}, 32'h0);
         wait_stack(E_INT);
         n_xt = n_xt - (s == 1 ? BLRS_REC_SHORT : REC_SIM);
         chk1(n_xt >= -1 && n_xt <= 1, 1'b1);
         axr(BLRS_OFF_BREAK_STATUS, 32'h0, BLRS_RESP_OKAY);
      end
      $display("test stop done");
      axw(BLRS_OFF_OPTION, 32'h0);
      evt(E_STOP);
      chk1(bad_seen, 1'b1);
      axr(BLRS_OFF_BREAK_STATUS, 32'h0000_1000, BLRS_RESP_OKAY);
      for (int b = 0; b < 6; b++) begin
         reset_src <= 6'h01 << b;
         @(posedge aclk);
         reset_src <= '0;
         axr(BLRS_OFF_BREAK_STATUS, 32'h1 << (b == 0 ? 9 : b + 10),
             BLRS_RESP_OKAY);
      end
      reset_src <= 6'h10;
      @(posedge aclk);
      reset_src <= 6'h20;
      @(posedge aclk);
      reset_src <= '0;
      axr(BLRS_OFF_BREAK_STATUS, 32'h0000_8000, BLRS_RESP_OKAY);
      $display("test reset cause done");
      wrap_up();
   end
endmodule
